// File: hw/audio_link_consts.svh
`ifndef AUDIO_LINK_CONSTS_SVH
`define AUDIO_LINK_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_RECFMT 12'h190
`define OFS_CHSEL 12'h1A0
`define OFS_VCTL 12'h200
`define OFS_FMT 12'h210
`define OFS_VMW 12'h220

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_FMT 11'h008
`define RST_VMW 5'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define REC_MONO 1
`define REC_W16 0
`define VC_CODEC_BYP 5
`define VC_VM_BYP 4
`define VC_ANALOG 3
`define VC_SMOOTH 2
`define VC_MIX 1
`define VC_CALL 0
`define FMT_CLKPOL 10
`define FMT_FSINV 9
`define FMT_LSB 8
`define FMT_LONG 7

// ----------------------------------------------------------------
// word widths, slot length, bus answers
// ----------------------------------------------------------------
`define MIN_W 5'h08
`define MAX_W 5'h18
`define SLOT_BITS 6'h20
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// link bit clock made by the modem end
// ----------------------------------------------------------------
`define CLK_NS 8
`define LINK_NS 80
`define HALF_CYC (`LINK_NS / `CLK_NS / 2)

`endif

// File: hw/audio_link_pkg.sv
`include "audio_link_consts.svh"

package audio_link_pkg;

   typedef enum logic [1:0] {tim_i2s, tim_left, tim_right, tim_pcm} tim_e;

   typedef struct packed {
      logic ok;
      logic ch;
      logic [4:0] k;
   } loc_s;

   // width outside 8..24 is served as the nearest end
   function automatic logic [4:0] clamp_w(input logic [4:0] w);
      if (w < `MIN_W)
         clamp_w = `MIN_W;
      else if (w > `MAX_W)
         clamp_w = `MAX_W;
      else
         clamp_w = w;
   endfunction : clamp_w

   // position of word bit number k (in send order) in a msb-aligned 24-bit box
   function automatic logic [4:0] bit_at(input logic [4:0] k, input logic [4:0] w,
                                         input logic lsb);
      bit_at = lsb ? 5'(`MAX_W - w + k) : 5'(5'h17 - k);
   endfunction : bit_at

   // which channel and which word bit a frame position carries
   function automatic loc_s locate(input tim_e t, input logic [4:0] w, input logic [5:0] p);
      loc_s l;
      logic [5:0] w6;
      logic [5:0] off;
      logic [5:0] q;
      w6 = {1'b0, w};
      if (t == tim_pcm)
      begin
         l.ch = p >= w6;
         q = l.ch ? 6'(p - w6) : p;
         l.ok = p < 6'(w6 << 1);
      end
      else
      begin
         off = (t == tim_i2s) ? 6'h01 : (t == tim_left) ? 6'h00 : 6'(`SLOT_BITS - w6);
         q = 6'({1'b0, p[4:0]} - off);
         l.ch = p[5];
         l.ok = ({1'b0, p[4:0]} >= off) && (q < w6);
      end
      l.k = q[4:0];
      locate = l;
   endfunction : locate

   typedef struct packed {
      logic [2:0] s0;
      logic [2:0] s1;
      logic bclk_q;
      logic fs_q;
      logic [5:0] cnt;
      loc_s loc;
      logic [23:0] asm_w;
      logic [15:0] left;
      logic ul;
      logic [31:0] pack;
      logic [2:0] pb;
      logic [31:0] fifo_data;
      logic fifo_valid;
      logic [15:0] mix;
      logic [1:0] recfmt;
      logic [3:0] chsel;
      logic [5:0] vctl;
      logic [10:0] fmt;
      logic [4:0] vmw;
      logic aw_got;
      logic [11:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dev_state_s;

   typedef struct packed {
      logic s0;
      logic s1;
      logic [7:0] div;
      logic bclk;
      logic [5:0] pos;
      logic fs;
      logic dl;
      loc_s loc;
      logic [23:0] tl;
      logic [23:0] tr;
      logic [23:0] asm_w;
      logic [23:0] rl;
      logic [23:0] rxl;
      logic [23:0] rxr;
      logic rxv;
      logic taken;
   } modem_state_s;

endpackage : audio_link_pkg

// File: hw/serial_link_if.sv
interface serial_link_if;
   logic bclk;
   logic fsync;
   logic dl_data;
   logic ul_data;

   modport device (input bclk, input fsync, input dl_data, output ul_data);
   modport modem (output bclk, output fsync, output dl_data, input ul_data);
endinterface : serial_link_if

// File: hw/audio_rx_end.sv
`include "audio_link_consts.svh"

module audio_rx_end (
   input wire logic aclk,
   input wire logic aresetn,
   serial_link_if.device link,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [15:0] uplink_left,
   input wire logic [15:0] uplink_right,
   input wire logic [15:0] background_sample,
   output logic [31:0] rx_fifo_wdata,
   output logic rx_fifo_wvalid,
   output logic [15:0] mixer_sample,
   output logic codec_bclk,
   output logic codec_lrck,
   output logic codec_data,
   output logic voice_master_bclk,
   output logic voice_master_lrck,
   output logic voice_master_data,
   output logic analog_path_sel,
   output logic [4:0] vm_word_width
);

   audio_link_pkg::dev_state_s st_r;
   audio_link_pkg::dev_state_s st_nxt;
   audio_link_pkg::tim_e tim;
   logic [4:0] w;
   logic rise;
   logic fall;
   logic launch;
   logic sample;
   logic fs;
   logic bnd;
   logic [5:0] cur;
   logic [23:0] up;
   logic [23:0] a;
   logic frame;
   logic [15:0] out_l;
   logic [15:0] out_r;
   logic [16:0] sum;
   logic [15:0] avg;
   logic [31:0] fb;
   logic [2:0] nb;
   logic [2:0] pbn;
   logic [31:0] pk;
   logic [16:0] msum;
   logic [15:0] m;
   logic [32:0] rd;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
   endfunction : merge

   function automatic logic [15:0] pick(input logic [1:0] sel, input logic [15:0] own,
                                        input logic [15:0] other, input logic [15:0] av);
      pick = sel[1] ? av : (sel[0] ? other : own);
   endfunction : pick

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.fifo_valid = 1'b0;
      st_nxt.s0 = {link.bclk, link.fsync, link.dl_data};
      st_nxt.s1 = st_r.s0;
      st_nxt.bclk_q = st_r.s1[2];
      w = audio_link_pkg::clamp_w(st_r.fmt[4:0]);
      tim = audio_link_pkg::tim_e'(st_r.fmt[6:5]);
      rise = st_r.s1[2] & ~st_r.bclk_q;
      fall = ~st_r.s1[2] & st_r.bclk_q;
      launch = st_r.fmt[`FMT_CLKPOL] ? fall : rise;
      sample = st_r.fmt[`FMT_CLKPOL] ? rise : fall;
      fs = st_r.s1[1] ^ st_r.fmt[`FMT_FSINV];
      bnd = 1'b0;
      cur = 6'h00;
      up = 24'h000000;
      a = st_r.asm_w;
      frame = 1'b0;
      // frame position is found at the launch edge so the uplink bit leaves in time
      if (launch)
      begin
         // in PCM mode only the sync's leading edge counts, so short and long sync both work; the other modes count either edge
         bnd = (tim == audio_link_pkg::tim_pcm) ? (fs & ~st_r.fs_q) : (fs ^ st_r.fs_q);
         cur = bnd ? 6'h00 : ((&st_r.cnt) ? st_r.cnt : 6'(st_r.cnt + 6'h01));
         st_nxt.cnt = cur;
         st_nxt.fs_q = fs;
         st_nxt.loc = audio_link_pkg::locate(tim, w,
            (tim == audio_link_pkg::tim_pcm) ? cur : {fs, cur[4:0]});
         up = {st_nxt.loc.ch ? uplink_right : uplink_left, 8'h00};
         st_nxt.ul = st_nxt.loc.ok &
            up[audio_link_pkg::bit_at(st_nxt.loc.k, w, st_r.fmt[`FMT_LSB])];
      end
      if (sample && st_r.loc.ok)
      begin
         if (st_r.loc.k == 5'h00)
            a = 24'h000000;
         a[audio_link_pkg::bit_at(st_r.loc.k, w, st_r.fmt[`FMT_LSB])] = st_r.s1[0];
         st_nxt.asm_w = a;
         if (st_r.loc.k == 5'(w - 5'h01))
         begin
            if (st_r.loc.ch)
               frame = 1'b1;
            else
               st_nxt.left = a[23:8];
         end
      end
      // ----------------------------------------------------------------
      // resampler, packer, mixer: once per received stereo frame
      // ----------------------------------------------------------------
      sum = 17'({st_r.left[15], st_r.left} + {a[23], a[23:8]});
      avg = sum[16:1];
      out_l = pick(st_r.chsel[3:2], st_r.left, a[23:8], avg);
      out_r = pick(st_r.chsel[1:0], a[23:8], st_r.left, avg);
      // 8-bit recording is unsigned: top byte with its sign bit flipped
      if (st_r.recfmt[`REC_MONO])
      begin
         fb = st_r.recfmt[`REC_W16] ? {16'h0000, out_l}
                                    : {24'h000000, out_l[15:8] ^ 8'h80};
         nb = st_r.recfmt[`REC_W16] ? 3'h2 : 3'h1;
      end
      else
      begin
         fb = st_r.recfmt[`REC_W16] ? {out_r, out_l}
            : {16'h0000, out_r[15:8] ^ 8'h80, out_l[15:8] ^ 8'h80};
         nb = st_r.recfmt[`REC_W16] ? 3'h4 : 3'h2;
      end
      pk = st_r.pack;
      // oldest sample lands in the lowest free byte
      for (int i = 0; i < 4; i++)
         if ((3'(i) >= st_r.pb) && (3'(i) < 3'(st_r.pb + nb)))
            pk[8*i +: 8] = fb[8*(i - int'(st_r.pb)) +: 8];
      pbn = 3'(st_r.pb + nb);
      msum = 17'({out_l[15], out_l} + {background_sample[15], background_sample});
      m = msum[16:1];
      if (frame)
      begin
         if (pbn == 3'h4)
         begin
            st_nxt.fifo_data = pk;
            st_nxt.fifo_valid = 1'b1;
            st_nxt.pack = 32'h00000000;
            st_nxt.pb = 3'h0;
         end
         else
         begin
            st_nxt.pack = pk;
            st_nxt.pb = pbn;
         end
         if (!st_r.vctl[`VC_MIX])
            st_nxt.mix = 16'h0000;
         else if (st_r.vctl[`VC_SMOOTH])
            st_nxt.mix = 16'(({m[15], m} + {st_r.mix[15], st_r.mix}) >>> 1);
         else
            st_nxt.mix = m;
      end
      // capture only while the call runs on the digital path; a stop drops the partial word
      if (!st_r.vctl[`VC_CALL] || st_r.vctl[`VC_ANALOG])
      begin
         st_nxt.pb = 3'h0;
         st_nxt.pack = 32'h00000000;
         st_nxt.fifo_valid = 1'b0;
      end
      // ----------------------------------------------------------------
      // register bus
      // ----------------------------------------------------------------
      if (awvalid && awready)
      begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = awaddr;
      end
      if (wvalid && wready)
      begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = wdata;
         st_nxt.wstrb = wstrb;
      end
      if (st_r.aw_got && st_r.w_got)
      begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `RESP_OK;
         unique case ({st_r.awaddr[11:2], 2'b00})
            `OFS_RECFMT: st_nxt.recfmt = 2'(merge({30'h0, st_r.recfmt}, st_r.wdata, st_r.wstrb));
            `OFS_CHSEL: st_nxt.chsel = 4'(merge({28'h0, st_r.chsel}, st_r.wdata, st_r.wstrb));
            `OFS_VCTL: st_nxt.vctl = 6'(merge({26'h0, st_r.vctl}, st_r.wdata, st_r.wstrb));
            `OFS_FMT: st_nxt.fmt = 11'(merge({21'h0, st_r.fmt}, st_r.wdata, st_r.wstrb));
            `OFS_VMW: st_nxt.vmw = 5'(merge({27'h0, st_r.vmw}, st_r.wdata, st_r.wstrb));
            default: st_nxt.bresp = `RESP_SLVERR;
         endcase
      end
      if (st_r.bvalid && bready)
         st_nxt.bvalid = 1'b0;
      unique case ({araddr[11:2], 2'b00})
         `OFS_RECFMT: rd = {1'b1, 30'h0, st_r.recfmt};
         `OFS_CHSEL: rd = {1'b1, 28'h0, st_r.chsel};
         `OFS_VCTL: rd = {1'b1, 26'h0, st_r.vctl};
         `OFS_FMT: rd = {1'b1, 21'h0, st_r.fmt};
         `OFS_VMW: rd = {1'b1, 27'h0, st_r.vmw};
         default: rd = 33'h000000000;
      endcase
      if (arvalid && arready)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd[31:0];
         st_nxt.rresp = rd[32] ? `RESP_OK : `RESP_SLVERR;
      end
      if (st_r.rvalid && rready)
         st_nxt.rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
         st_r.fmt <= `RST_FMT;
         st_r.vmw <= `RST_VMW;
      end
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign awready = ~st_r.aw_got & ~st_r.bvalid;
   assign wready = ~st_r.w_got & ~st_r.bvalid;
   assign bvalid = st_r.bvalid;
   assign bresp = st_r.bresp;
   assign arready = ~st_r.rvalid;
   assign rvalid = st_r.rvalid;
   assign rdata = st_r.rdata;
   assign rresp = st_r.rresp;
   assign link.ul_data = st_r.ul;
   assign rx_fifo_wdata = st_r.fifo_data;
   assign rx_fifo_wvalid = st_r.fifo_valid;
   assign mixer_sample = st_r.mix;
   // passthroughs carry the resynchronised link, two cycles late
   assign codec_bclk = st_r.vctl[`VC_CODEC_BYP] & st_r.s1[2];
   assign codec_lrck = st_r.vctl[`VC_CODEC_BYP] & st_r.s1[1];
   assign codec_data = st_r.vctl[`VC_CODEC_BYP] & st_r.s1[0];
   assign voice_master_bclk = st_r.vctl[`VC_VM_BYP] & st_r.s1[2];
   assign voice_master_lrck = st_r.vctl[`VC_VM_BYP] & st_r.s1[1];
   assign voice_master_data = st_r.vctl[`VC_VM_BYP] & st_r.s1[0];
   assign analog_path_sel = st_r.vctl[`VC_ANALOG];
   assign vm_word_width = st_r.vmw;

endmodule : audio_rx_end

// File: hw/audio_modem_end.sv
`include "audio_link_consts.svh"

module audio_modem_end #(
   parameter int HALF = `HALF_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   serial_link_if.modem link,
   input wire logic run,
   input wire logic [1:0] tim_sel,
   input wire logic lsb_first,
   input wire logic long_sync,
   input wire logic clk_pol,
   input wire logic [4:0] word_width,
   input wire logic [23:0] tx_left,
   input wire logic [23:0] tx_right,
   output logic tx_taken,
   output logic [23:0] rx_left,
   output logic [23:0] rx_right,
   output logic rx_valid
);

   // the far end needs about six cycles to turn an uplink bit round
   if (HALF < 4 || HALF > 255)
      $error("HALF must lie in 4..255");

   audio_link_pkg::modem_state_s st_r;
   audio_link_pkg::modem_state_s st_nxt;
   audio_link_pkg::tim_e tim;
   logic [4:0] w;
   logic [5:0] last;
   logic [5:0] p;
   logic [23:0] a;
   logic [23:0] wd;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s0 = link.ul_data;
      st_nxt.s1 = st_r.s0;
      st_nxt.rxv = 1'b0;
      st_nxt.taken = 1'b0;
      w = audio_link_pkg::clamp_w(word_width);
      tim = audio_link_pkg::tim_e'(tim_sel);
      last = (tim == audio_link_pkg::tim_pcm) ? 6'({w, 1'b0} - 6'h01) : 6'h3F;
      p = 6'h00;
      a = st_r.asm_w;
      wd = 24'h000000;
      if (!run)
      begin
         st_nxt.div = 8'h00;
         st_nxt.bclk = 1'b0;
         st_nxt.pos = 6'h3F;
         st_nxt.fs = 1'b0;
         st_nxt.dl = 1'b0;
         st_nxt.loc = '0;
      end
      else if (st_r.div == 8'(HALF - 1))
      begin
         st_nxt.div = 8'h00;
         st_nxt.bclk = ~st_r.bclk;
         // launch on rising at polarity 0, on falling at polarity 1
         if (~st_r.bclk ^ clk_pol)
         begin
            // uplink bit of the previous position is read a whole bit late
            if (st_r.loc.ok)
            begin
               if (st_r.loc.k == 5'h00)
                  a = 24'h000000;
               a[audio_link_pkg::bit_at(st_r.loc.k, w, lsb_first)] = st_r.s1;
               st_nxt.asm_w = a;
               if (st_r.loc.k == 5'(w - 5'h01))
               begin
                  if (st_r.loc.ch)
                  begin
                     st_nxt.rxl = st_r.rl;
                     st_nxt.rxr = a;
                     st_nxt.rxv = 1'b1;
                  end
                  else
                     st_nxt.rl = a;
               end
            end
            p = (st_r.pos >= last) ? 6'h00 : 6'(st_r.pos + 6'h01);
            st_nxt.pos = p;
            if (p == 6'h00)
            begin
               st_nxt.tl = tx_left;
               st_nxt.tr = tx_right;
               st_nxt.taken = 1'b1;
            end
            st_nxt.loc = audio_link_pkg::locate(tim, w, p);
            wd = st_nxt.loc.ch ? st_nxt.tr : st_nxt.tl;
            st_nxt.dl = st_nxt.loc.ok &
               wd[audio_link_pkg::bit_at(st_nxt.loc.k, w, lsb_first)];
            if (tim == audio_link_pkg::tim_pcm)
               st_nxt.fs = long_sync ? (p < {1'b0, w}) : (p == 6'h00);
            else
               st_nxt.fs = (tim == audio_link_pkg::tim_i2s) ? p[5] : ~p[5];
         end
      end
      else
         st_nxt.div = 8'(st_r.div + 8'h01);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
         st_r.pos <= 6'h3F;
      end
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.bclk = st_r.bclk;
   assign link.fsync = st_r.fs;
   assign link.dl_data = st_r.dl;
   assign tx_taken = st_r.taken;
   assign rx_left = st_r.rxl;
   assign rx_right = st_r.rxr;
   assign rx_valid = st_r.rxv;

endmodule : audio_modem_end

// File: bench/audio_link_chk.sv
module audio_link_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bclk,
   input wire logic fsync,
   input wire logic dl_data,
   input wire logic ul_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // wire timing, half bit period of 5 cycles
   // ------------------------------------------------------------
   bclk_half_a: assert property ($changed(bclk) |=> $stable(bclk) [*4])
      else $error("bit clock half period short");
   sync_launch_a: assert property ($changed(fsync) |-> $changed(bclk))
      else $error("frame sync off clock edge");
   dl_launch_a: assert property ($changed(dl_data) |-> $changed(bclk))
      else $error("downlink data off clock edge");
   ul_quiet_a: assert property ($changed(bclk) |-> $stable(ul_data) ##1 $stable(ul_data))
      else $error("uplink data moved too early");
   sync_hold_a: assert property ($changed(fsync) |=> $stable(fsync) [*8])
      else $error("frame sync too short");
   dl_hold_a: assert property ($changed(dl_data) |=> $stable(dl_data) [*8])
      else $error("downlink bit too short");
   ul_hold_a: assert property ($changed(ul_data) |=> $stable(ul_data) [*8])
      else $error("uplink bit too short");
   link_idle_a: assert property ($rose(aresetn) |-> !bclk && !fsync && !dl_data && !ul_data)
      else $error("link not idle after reset");
endmodule : audio_link_chk

// File: bench/audio_rx_pack_and_voice_routing_tb.sv
`include "audio_link_consts.svh"

module audio_rx_pack_and_voice_routing_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
   logic run = 1'h0, seq = 1'h0, lsb_first = 1'h0, long_sync = 1'h0, clk_pol = 1'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [1:0] tim_sel = 2'h0;
   logic [4:0] word_width = 5'h10;
   logic [7:0] n = 8'h00;
   logic [23:0] cl = 24'h9A5C00, cr = 24'h31C700;
   logic [15:0] bg = 16'h0800, ul_l = 16'hC3A1, ul_r = 16'h5E27;
   int checks = 0, n_mismatch = 0;
   wire awready, wready, bvalid, arready, rvalid, rx_fifo_wvalid, codec_bclk;
   wire voice_master_bclk, analog_path_sel, tx_taken, rx_valid;
   wire codec_lrck, codec_data, voice_master_lrck, voice_master_data;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata, rx_fifo_wdata;
   wire [15:0] mixer_sample;
   wire [4:0] vm_word_width;
   wire [23:0] rx_left, rx_right, tx_left, tx_right;

   serial_link_if lk ();
   audio_rx_end i_audio_rx_end (.aclk(aclk), .aresetn(aresetn), .link(lk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .uplink_left(ul_l), .uplink_right(ul_r), .background_sample(bg),
      .rx_fifo_wdata(rx_fifo_wdata), .rx_fifo_wvalid(rx_fifo_wvalid),
      .mixer_sample(mixer_sample), .codec_bclk(codec_bclk), .codec_lrck(codec_lrck),
      .codec_data(codec_data), .voice_master_bclk(voice_master_bclk),
      .voice_master_lrck(voice_master_lrck), .voice_master_data(voice_master_data),
      .analog_path_sel(analog_path_sel), .vm_word_width(vm_word_width));
   audio_modem_end i_audio_modem_end (.aclk(aclk), .aresetn(aresetn), .link(lk), .run(run),
      .tim_sel(tim_sel), .lsb_first(lsb_first), .long_sync(long_sync), .clk_pol(clk_pol),
      .word_width(word_width), .tx_left(tx_left), .tx_right(tx_right), .tx_taken(tx_taken),
      .rx_left(rx_left), .rx_right(rx_right), .rx_valid(rx_valid));
   audio_link_chk i_audio_link_chk (.aclk(aclk), .aresetn(aresetn), .bclk(lk.bclk),
      .fsync(lk.fsync), .dl_data(lk.dl_data), .ul_data(lk.ul_data));

   // frame numbered samples make the packing order visible
   assign tx_left = seq ? {n, 16'h5A00} : cl;
   assign tx_right = seq ? {n + 8'h40, 16'hA500} : cr;
   always @(posedge aclk)
      if (tx_taken)
         n <= n + 8'h01;

   initial
      forever #4 aclk = ~aclk;

   // ------------------------------------------------------------
   // bus and link helpers
   // ------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      forever
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            r = bresp;
            break;
         end
      end
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      forever
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            break;
         end
      end
   endtask : rd

   task automatic wait_ev(input logic fifo, output logic got);
      got = 1'h0;
      for (int i = 0; i < 1500 && !got; i++)
      begin
         @(posedge aclk);
         got = fifo ? rx_fifo_wvalid : rx_valid;
      end
   endtask : wait_ev

   // both ends restart so the first frame is captured whole
   task automatic setup(input logic [10:0] f, input logic [1:0] rf, input logic [5:0] vc);
      logic [1:0] r;
      @(posedge aclk);
      aresetn <= 1'h0;
      run <= 1'h0;
      {clk_pol, lsb_first, long_sync, tim_sel, word_width} <= {f[10], f[8:0]};
      repeat (2) @(posedge aclk);
      n <= 8'h00;
      aresetn <= 1'h1;
      wr(`OFS_FMT, 32'(f), r);
      wr(`OFS_RECFMT, 32'(rf), r);
      wr(`OFS_VCTL, 32'(vc), r);
      run <= 1'h1;
   endtask : setup

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rd(`OFS_FMT, d, r);
      `CHK("fmt reset", 32'h00000008, d)
      rd(`OFS_VCTL, d, r);
      `CHK("vctl reset", 32'h00000000, d)
      rd(12'h204, d, r);
      `CHK("unmapped read", `RESP_SLVERR, r)
      wr(12'h204, 32'h0000FFFF, r);
      `CHK("unmapped write", `RESP_SLVERR, r)
      wr(`OFS_VCTL, 32'hFFFFFFFF, r);
      rd(`OFS_VCTL, d, r);
      `CHK("vctl rw", 32'h0000003F, d)
      wr(`OFS_VMW, 32'h0000000D, r);
      `CHK("vm width", 5'h0D, vm_word_width)
   endtask : t_regs

   task automatic t_pack;
      logic [1:0] rf [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
      logic [31:0] ex [4] = '{32'h83828180, 32'hC181C080, 32'h015A005A, 32'h40A5005A};
      logic g;
      seq <= 1'h1;
      for (int k = 0; k < 4; k++)
      begin
         setup(11'h070, rf[k], 6'h01);
         wait_ev(1'h1, g);
         `CHK("packed word", ex[k], rx_fifo_wdata)
      end
   endtask : t_pack

   task automatic t_formats;
      logic [10:0] fm [4] = '{11'h010, 11'h332, 11'h658, 11'h5F0}; // pcm width kept 16
      logic g;
      seq <= 1'h0;
      for (int k = 0; k < 4; k++)
      begin
         setup(fm[k], 2'h1, 6'h01);
         repeat (2) wait_ev(1'h1, g);
         `CHK("downlink word", 32'h31C79A5C, rx_fifo_wdata)
         repeat (2) wait_ev(1'h0, g);
         `CHK("uplink left", 16'hC3A1, rx_left[23:8])
         `CHK("uplink right", 16'h5E27, rx_right[23:8])
      end
   endtask : t_formats

   // left plus right overflows 16 bits, so a narrow sum shows
   task automatic t_mixer;
      logic [15:0] ex [4] = '{16'h3C00, 16'h2C00, 16'h3400, 16'h3400};
      logic [1:0] r;
      logic g;
      cl <= 24'h700000;
      cr <= 24'h500000;
      setup(11'h010, 2'h1, 6'h03);
      for (int k = 0; k < 4; k++)
      begin
         wr(`OFS_CHSEL, 32'(k << 2), r);
         repeat (3) wait_ev(1'h1, g);
         `CHK("mixer", ex[k], mixer_sample)
      end
      wr(`OFS_VCTL, 32'h00000001, r);
      repeat (3) wait_ev(1'h1, g);
      `CHK("mixer off", 16'h0000, mixer_sample)
      // from a zero history the first smoothed output is half the new mix
      wr(`OFS_VCTL, 32'h00000007, r);
      wait_ev(1'h1, g);
      `CHK("smoothed", 16'h1A00, mixer_sample)
   endtask : t_mixer

   task automatic t_refuse;
      logic [1:0] r;
      logic g;
      setup(11'h010, 2'h1, 6'h09);
      wait_ev(1'h1, g);
      `CHK("analog capture", 1'h0, g)
      wr(`OFS_VCTL, 32'h00000000, r);
      wait_ev(1'h1, g);
      `CHK("call off capture", 1'h0, g)
   endtask : t_refuse

   task automatic t_route(input logic [5:0] vc);
      int cb;
      int cv;
      int ce;
      logic [3:0] pq;
      logic [1:0] r;
      cb = 0;
      cv = 0;
      ce = 0;
      pq = 4'h0;
      wr(`OFS_VCTL, 32'(vc), r);
      for (int i = 0; i < 100; i++)
      begin
         @(posedge aclk);
         cb += int'(codec_bclk);
         cv += int'(voice_master_bclk);
         // outputs show the pins as they stood two edges earlier
         if (i > 1)
            ce += int'({codec_lrck, codec_data, voice_master_lrck, voice_master_data} !==
               ({vc[5], vc[5], vc[4], vc[4]} & {2{pq[3:2]}}));
         pq = {pq[1:0], lk.fsync, lk.dl_data};
      end
      `CHK("pass lines", 0, ce)
      `CHK("codec bclk", vc[5] ? 50 : 0, cb)
      `CHK("vm bclk", vc[4] ? 50 : 0, cv)
      `CHK("analog", vc[3], analog_path_sel)
   endtask : t_route

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_pack();
      t_formats();
      t_mixer();
      t_refuse();
      t_route(6'h38);
      t_route(6'h00);
      end_sim();
   end

   initial
   begin
      repeat (70000) @(posedge aclk);
      n_mismatch++;
      end_sim();
   end
endmodule : audio_rx_pack_and_voice_routing_tb
